// [hdl/lshc_pkg.sv]
/*
 * Shared constants for the line interface serial control block.
 * Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
 */
// Contract
// - In hardware mode with mute enabled, a channel in loss of signal drives both recovered data outputs low.
// - With mute disabled, loss of signal never alters the recovered data outputs.
// - In host mode the mute pin is ignored; the board ties it low and a pull-down holds it low.
// - Each serial input bit is captured on a rising serial clock edge in host mode.
// - A read shifts the addressed command register out on the serial data output.
// - The serial data output changes only on falling serial clock edges during read data.
// - The serial data output is released to high impedance once the transfer ends.
// - In hardware mode the serial clock pin high shuts off all receivers, low enables them.
// - In host mode the register reset input low returns all command registers to defaults.
// - Each channel drives its loss of signal indicator high while it detects loss of signal.
package lshc_pkg;
    localparam int NUM_CHAN = 4;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_CMD = 8;
    localparam logic [7:0] CMD_DEFAULT = 8'h00;
    // Command register 0 fields
    localparam int CMD0_MUTE_BIT = 0;
    localparam int CMD0_RECEIVER_SHUTOFF_BIT = 1;
    // Serial frame: 1 read/write bit, 5 address bits, 8 data bits
    localparam logic [3:0] CNT_ADDR_LAST = 4'h5;
    localparam logic [3:0] CNT_DATA_FIRST = 4'h6;
    localparam logic [3:0] CNT_DATA_LAST = 4'hD;
    localparam logic [3:0] FRAME_BITS = 4'hE;
    // Avalon byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CMD_BASE = 8'h10;
    // Status register fields
    localparam int ST_LOS_LSB = 0;
    localparam int ST_HOST_BIT = 4;
    localparam int ST_RECEIVER_SHUTOFF_BIT = 5;
    localparam int ST_BUSY_BIT = 6;
endpackage

// [hdl/lshc_sync.sv]
/*
 * Two-stage synchroniser for a bundle of asynchronous pins.
 * Assumes a synchronous active-high reset on the sampling clock.
 */
`timescale 1ns/1ns
`default_nettype none
module lshc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } lshc_sync_s;

    lshc_sync_s st_reg;
    lshc_sync_s st_next;

    always_comb
    begin
        st_next.meta = i_async;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            st_reg <= {RST_VAL, RST_VAL};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.stable;
endmodule
`default_nettype wire

// [hdl/lshc_top.sv]
/*
 * Serial host control port, mute-on-LOS and receiver shut-off logic.
 * Pins are asynchronous and synchronised here; the serial clock is
 * oversampled by I_SYS_CLK, so it must stay well below 31 MHz.
 */
`timescale 1ns/1ns
`default_nettype none
module lshc_top
    import lshc_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic I_HOST_MODE,
    input wire logic I_CHIP_SELECT_N,
    input wire logic I_SCLK,
    input wire logic I_SDI,
    input wire logic I_REGISTER_RESET_INPUT_N,
    input wire logic I_MUTE_ON_LOS_ENABLE,
    input wire logic [NUM_CHAN-1:0] I_LOS_DETECT,
    input wire logic [NUM_CHAN-1:0] I_RECV_POSITIVE_DATA,
    input wire logic [NUM_CHAN-1:0] I_RECV_NEGATIVE_DATA,
    output logic O_SDO,
    output logic O_SDO_OE_N,
    output logic O_RECEIVER_SHUTOFF,
    output logic [NUM_CHAN-1:0] O_LOS_INDICATOR,
    output logic [NUM_CHAN-1:0] O_RECV_POSITIVE_DATA,
    output logic [NUM_CHAN-1:0] O_RECV_NEGATIVE_DATA,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST
);
    localparam int SW = 6 + 3 * NUM_CHAN;

    typedef struct packed {
        logic [NUM_CHAN-1:0] los;
        logic [NUM_CHAN-1:0] rpos;
        logic [NUM_CHAN-1:0] rneg;
        logic rx_off;
        logic sdo;
        logic sdo_oe_n;
        logic sclk_d;
        logic [3:0] cnt;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] shin;
        logic [DATA_W-1:0] shout;
        logic [NUM_CMD-1:0][DATA_W-1:0] cmd;
        logic waitreq;
        logic [31:0] rdata;
    } lshc_state_s;

    lshc_state_s s_reg;
    lshc_state_s s_next;
    logic [SW-1:0] sync_out;
    logic host_s, cs_n_s, sclk_s, sdi_s, regrst_n_s, mute_pin_s;
    logic [NUM_CHAN-1:0] los_s, rpos_s, rneg_s;
    logic active, rise, fall, mute_active;
    logic [NUM_CHAN-1:0] mute_vec;
    logic [ADDR_W-1:0] addr_full;

    lshc_sync #(
        .WIDTH(SW),
        .RST_VAL({2'b01, 2'b00, 2'b10, {(3 * NUM_CHAN){1'b0}}})
    ) u_sync (
        .i_clk(I_SYS_CLK),
        .i_reset(I_RESET),
        .i_async({I_HOST_MODE, I_CHIP_SELECT_N, I_SCLK, I_SDI,
                  I_REGISTER_RESET_INPUT_N, I_MUTE_ON_LOS_ENABLE,
                  I_LOS_DETECT, I_RECV_POSITIVE_DATA,
                  I_RECV_NEGATIVE_DATA}),
        .o_sync(sync_out)
    );

    assign {host_s, cs_n_s, sclk_s, sdi_s, regrst_n_s, mute_pin_s,
            los_s, rpos_s, rneg_s} = sync_out;

    // Maps a bus byte address onto a command register index
    function automatic logic cmd_hit(input logic [7:0] a);
        cmd_hit = (a >= OFS_CMD_BASE) && (a[1:0] == 2'b00)
            && (a < 8'(OFS_CMD_BASE + 8'(4 * NUM_CMD)));
    endfunction

    function automatic logic [2:0] cmd_idx(input logic [7:0] a);
        logic [7:0] d;
        d = 8'(a - OFS_CMD_BASE);
        cmd_idx = d[4:2];
    endfunction

    function automatic logic [DATA_W-1:0] cmd_word(
        input logic [NUM_CMD-1:0][DATA_W-1:0] c,
        input logic [ADDR_W-1:0] a);
        cmd_word = (a < ADDR_W'(NUM_CMD)) ? c[a[2:0]] : '0;
    endfunction

    // The pin is ignored in host mode; the command register takes over
    assign mute_active = host_s ? s_reg.cmd[0][CMD0_MUTE_BIT]
                                : mute_pin_s;
    assign active = host_s && !cs_n_s;
    assign rise = sclk_s && !s_reg.sclk_d;
    assign fall = !sclk_s && s_reg.sclk_d;
    assign addr_full = {s_reg.addr[ADDR_W-2:0], sdi_s};

    always_comb
    begin
        s_next = s_reg;
        s_next.sclk_d = sclk_s;
        // Channel outputs
        mute_vec = {NUM_CHAN{mute_active}} & los_s;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            s_next.los[i] = los_s[i];
            s_next.rpos[i] = rpos_s[i] & ~mute_vec[i];
            s_next.rneg[i] = rneg_s[i] & ~mute_vec[i];
        end
        s_next.rx_off = host_s ? s_reg.cmd[0][CMD0_RECEIVER_SHUTOFF_BIT]
                               : sclk_s;

        // Avalon slave: answer one cycle after the request appears,
        // commit the write on the edge that sees waitrequest low
        if ((I_AVS_READ || I_AVS_WRITE) && s_reg.waitreq)
        begin
            s_next.waitreq = 1'b0;
            s_next.rdata = '0;
            if (I_AVS_READ && I_AVS_ADDRESS == OFS_STATUS)
            begin
                s_next.rdata[ST_LOS_LSB +: NUM_CHAN] = s_reg.los;
                s_next.rdata[ST_HOST_BIT] = host_s;
                s_next.rdata[ST_RECEIVER_SHUTOFF_BIT] = s_reg.rx_off;
                s_next.rdata[ST_BUSY_BIT] = active;
            end
            else if (I_AVS_READ && cmd_hit(I_AVS_ADDRESS))
            begin
                s_next.rdata[DATA_W-1:0] = s_reg.cmd[cmd_idx(I_AVS_ADDRESS)];
            end
        end
        else if ((I_AVS_READ || I_AVS_WRITE) && !s_reg.waitreq)
        begin
            s_next.waitreq = 1'b1;
            if (I_AVS_WRITE && I_AVS_BYTEENABLE[0]
                && cmd_hit(I_AVS_ADDRESS))
            begin
                s_next.cmd[cmd_idx(I_AVS_ADDRESS)] =
                    I_AVS_WRITEDATA[DATA_W-1:0];
            end
        end

        // Serial engine; placed after the bus so a serial write wins
        if (!active)
        begin
            s_next.cnt = '0;
            s_next.sdo_oe_n = 1'b1;
        end
        else if (rise && s_reg.cnt < FRAME_BITS)
        begin
            s_next.cnt = 4'(s_reg.cnt + 4'h1);
            if (s_reg.cnt == 4'h0)
            begin
                s_next.rw = sdi_s;
            end
            else if (s_reg.cnt <= CNT_ADDR_LAST)
            begin
                s_next.addr = addr_full;
                if (s_reg.cnt == CNT_ADDR_LAST)
                begin
                    s_next.shout = cmd_word(s_reg.cmd, addr_full);
                end
            end
            else
            begin
                s_next.shin = {s_reg.shin[DATA_W-2:0], sdi_s};
                if (s_reg.cnt == CNT_DATA_LAST && !s_reg.rw
                    && s_reg.addr < ADDR_W'(NUM_CMD))
                begin
                    s_next.cmd[s_reg.addr[2:0]] =
                        {s_reg.shin[DATA_W-2:0], sdi_s};
                end
            end
        end
        else if (fall)
        begin
            if (s_reg.rw && s_reg.cnt >= CNT_DATA_FIRST
                && s_reg.cnt <= CNT_DATA_LAST)
            begin
                s_next.sdo = s_reg.shout[DATA_W-1];
                s_next.shout = {s_reg.shout[DATA_W-2:0], 1'b0};
                s_next.sdo_oe_n = 1'b0;
            end
            else if (s_reg.cnt == FRAME_BITS)
            begin
                s_next.sdo_oe_n = 1'b1;
            end
        end

        // In host mode the register reset pin overrides any write in the same cycle
        if (host_s && !regrst_n_s)
        begin
            s_next.cmd = {NUM_CMD{CMD_DEFAULT}};
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RESET)
        begin
            s_reg <= '0;
            s_reg.cmd <= {NUM_CMD{CMD_DEFAULT}};
            s_reg.sdo_oe_n <= 1'b1;
            s_reg.waitreq <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign O_SDO = s_reg.sdo;
    assign O_SDO_OE_N = s_reg.sdo_oe_n;
    assign O_RECEIVER_SHUTOFF = s_reg.rx_off;
    assign O_LOS_INDICATOR = s_reg.los;
    assign O_RECV_POSITIVE_DATA = s_reg.rpos;
    assign O_RECV_NEGATIVE_DATA = s_reg.rneg;
    assign O_AVS_READDATA = s_reg.rdata;
    assign O_AVS_WAITREQUEST = s_reg.waitreq;

    default clocking dcb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);

    a_mute_forces_low: assert property (
        !host_s && mute_pin_s
        |=> ((O_RECV_POSITIVE_DATA | O_RECV_NEGATIVE_DATA)
             & $past(los_s)) == '0)
        else $error("muted channel shows data");
    a_no_mute_pass: assert property (
        !mute_active |=> O_RECV_POSITIVE_DATA == $past(rpos_s)
                         && O_RECV_NEGATIVE_DATA == $past(rneg_s))
        else $error("data altered without mute");
    a_host_ignores_pin: assert property (
        host_s && !s_reg.cmd[0][CMD0_MUTE_BIT]
        |=> O_RECV_POSITIVE_DATA == $past(rpos_s)
            && O_RECV_NEGATIVE_DATA == $past(rneg_s))
        else $error("mute pin acted in host mode");
    a_rise_counts_bit: assert property (
        active && rise && s_reg.cnt < FRAME_BITS
        |=> s_reg.cnt == 4'($past(s_reg.cnt) + 4'h1))
        else $error("serial bit not captured on rise");
    a_read_loads_word: assert property (
        active && rise && s_reg.cnt == CNT_ADDR_LAST
        |=> s_reg.shout == cmd_word($past(s_reg.cmd), $past(addr_full)))
        else $error("read word not loaded");
    a_sdo_on_fall: assert property (
        $changed(O_SDO) |-> $past(fall))
        else $error("serial output moved off a falling edge");
    a_release_end: assert property (
        active && fall && s_reg.cnt == FRAME_BITS |=> O_SDO_OE_N)
        else $error("serial output not released at frame end");
    a_hw_shutoff: assert property (
        !host_s |=> O_RECEIVER_SHUTOFF == $past(sclk_s))
        else $error("receiver shutoff does not follow pin");
    a_reg_reset: assert property (
        host_s && !regrst_n_s |=> s_reg.cmd == {NUM_CMD{CMD_DEFAULT}})
        else $error("command registers not reset");
    a_los_follows: assert property (
        ##1 O_LOS_INDICATOR == $past(los_s))
        else $error("loss indicator wrong");
    a_idle_released: assert property (
        !active |=> O_SDO_OE_N && s_reg.cnt == 4'h0)
        else $error("serial port active without chip select");
endmodule
`default_nettype wire

// [test/lshc_host_model.sv]
/*
 * Behavioural microprocessor on the four-wire serial control port.
 * Assumes host mode is selected before xfer is called.
 */
`timescale 1ns/1ns
`default_nettype none
module lshc_host_model (
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    output logic rd_done,
    output logic [7:0] rdata,
    input wire logic sdo
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        rd_done = 1'b0;
        rdata = 8'h00;
    end
    // Hardware mode reuses the clock pin as a level
    task automatic shutoff(input logic v);
        sclk <= v;
    endtask
    // Clock stands still outside a frame; half periods give 125 ns
    task automatic xfer(input logic rw, input logic [4:0] a,
        input logic [7:0] d);
        logic [13:0] f;
        f = {rw, a, d};
        cs_n <= 1'b0;
        #63;
        for (int i = 13; i >= 0; i--)
        begin
            sclk = 1'b0;
            // Released during read data, so toggle rather than hold
            sdi = (rw && i < 8) ? ~sdi : f[i];
            #62;
            sclk = 1'b1;
            if (i < 8)
                rdata[i] = sdo;
            #63;
        end
        sclk = 1'b0;
        #62;
        cs_n = 1'b1;
        rd_done = rw;
        #8;
        rd_done = 1'b0;
        // Deselect long enough for the synchroniser to see it
        #117;
    endtask
endmodule
`default_nettype wire

// [test/lshc_top_tb.sv]
/*
 * Self-checking bench for the serial host control block.
 * Assumes the model above stands in for the microprocessor.
 */
`timescale 1ns/1ns
`default_nettype none
module lshc_top_tb;
    import lshc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, host = 1'b0, mute = 1'b0, rr_n = 1'b1;
    logic [3:0] los = 4'h0, pd = 4'h0, nd = 4'h0, be = 4'hF;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0, wr = 1'b0;
    logic [31:0] wd = 32'h0, r;
    wire logic cs_n, sclk, sdi, rd_done, sdo, oe_n, shut, wreq, sdo_w;
    wire logic [7:0] srd;
    wire logic [3:0] los_o, po, no;
    wire logic [31:0] rdat;
    logic [31:0] exp_bus[$];
    logic [7:0] exp_ser[$];
    int num_errors = 0, num_checks = 0, seed = 91096;
    // Released line shows the inverse so a late enable is caught
    assign sdo_w = oe_n ? ~sdo : sdo;
    always #4 clk = ~clk;
    lshc_host_model host_m (.cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .rd_done(rd_done), .rdata(srd), .sdo(sdo_w));
    lshc_top uut (.I_SYS_CLK(clk), .I_RESET(rst), .I_HOST_MODE(host),
        .I_CHIP_SELECT_N(cs_n), .I_SCLK(sclk), .I_SDI(sdi),
        .I_REGISTER_RESET_INPUT_N(rr_n), .I_MUTE_ON_LOS_ENABLE(mute),
        .I_LOS_DETECT(los), .I_RECV_POSITIVE_DATA(pd),
        .I_RECV_NEGATIVE_DATA(nd), .O_SDO(sdo), .O_SDO_OE_N(oe_n),
        .O_RECEIVER_SHUTOFF(shut), .O_LOS_INDICATOR(los_o),
        .O_RECV_POSITIVE_DATA(po), .O_RECV_NEGATIVE_DATA(no),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq));
    task automatic check(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic rw, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= rw;
        wr <= ~rw;
        addr <= a;
        wd <= d;
        // Settled value looked at between edges to avoid an edge race
        do
        begin
            @(negedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0)
        begin
            num_errors++;
            conclude();
        end
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a, input logic [31:0] e);
        exp_bus.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    task automatic sread(input logic [4:0] a, input logic [7:0] e);
        exp_ser.push_back(e);
        host_m.xfer(1'b1, a, 8'h00);
    endtask
    task automatic pins;
        repeat (5) @(posedge clk);
    endtask
    always @(negedge clk)
        if (rd && wreq === 1'b0)
            check("avs_readdata", rdat, exp_bus.pop_front());
    always @(posedge rd_done)
        check("sdo_word", srd, exp_ser.pop_front());
    initial
    begin
        #500000;
        num_errors++;
        conclude();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("oe_n_reset", oe_n, 1'b1);
        host <= 1'b1;
        pins();
        rdb(OFS_STATUS, 32'h10);
        r = $random(seed);
        bus(1'b0, 8'h1C, r);
        rdb(8'h1C, {24'h0, r[7:0]});
        rdb(8'h0C, 32'h0);
        host_m.xfer(1'b0, 5'h02, r[15:8]);
        pins();
        rdb(8'h18, {24'h0, r[15:8]});
        sread(5'h03, r[7:0]);
        sread(5'h02, r[15:8]);
        sread(5'h09, 8'h00);
        pins();
        check("oe_n_idle", oe_n, 1'b1);
        rr_n <= 1'b0;
        pins();
        rr_n <= 1'b1;
        pins();
        rdb(8'h1C, 32'h0);
        rdb(8'h18, 32'h0);
        mute <= 1'b1;
        los <= 4'hF;
        pd <= 4'hA;
        pins();
        check("host_mute_ignored", po, 4'hA);
        bus(1'b0, OFS_CMD_BASE, 32'h3);
        pins();
        check("host_mute_reg", po, 4'h0);
        check("host_rx_off", shut, 1'b1);
        rr_n <= 1'b0;
        pins();
        rr_n <= 1'b1;
        pins();
        check("host_unmute", po, 4'hA);
        check("host_rx_on", shut, 1'b0);
        host <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            mute <= i[2];
            los <= r[3:0];
            pd <= r[7:4];
            nd <= r[11:8];
            pins();
            check("los_ind", los_o, r[3:0]);
            check("pos", po, i[2] ? r[7:4] & ~r[3:0] : r[7:4]);
            check("neg", no, i[2] ? r[11:8] & ~r[3:0] : r[11:8]);
        end
        host_m.shutoff(1'b1);
        pins();
        check("rx_off", shut, 1'b1);
        host_m.shutoff(1'b0);
        pins();
        check("rx_on", shut, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
